// >>> hdl/ocd_cmd_consts.vh
/*
 constants for the debug command interpreter: command codes, control
 register fields, reset values and interpreter state codes.
 assumes it is included once per compile unit by its bare name.
*/
`ifndef OCD_CMD_CONSTS_VH
`define OCD_CMD_CONSTS_VH

// command codes
`define CMD_RD_COUNTER 8'h03
`define CMD_WR_CONTROL 8'h04
`define CMD_RD_CONTROL 8'h05
`define CMD_WR_PC 8'h06
`define CMD_RD_PC 8'h07
`define CMD_WR_REG 8'h08

// control register fields
`define CTL_DEBUG_MODE_BIT 7
`define CTL_BRK_ENABLE_BIT 6
`define CTL_COUNT_ENABLE_BIT 5
`define CTL_RESET 8'h00

// values and reset states
`define BLOCKED_WORD 16'hFFFF
`define COUNTER_RESET 16'hFFFF
`define FULL_BLOCK 9'h100

// flash control register window in the register file
`define FLASH_CTL_FIRST 12'hFF8
`define FLASH_CTL_LAST 12'hFFF

// interpreter states
`define ST_IDLE 4'h0
`define ST_CTL_DATA 4'h1
`define ST_PC_HI 4'h2
`define ST_PC_LO 4'h3
`define ST_ADDR_HI 4'h4
`define ST_ADDR_LO 4'h5
`define ST_SIZE 4'h6
`define ST_DATA 4'h7
`define ST_TX_FIRST 4'h8
`define ST_TX_SECOND 4'h9

`endif

// >>> hdl/ocd_command_interpreter.v
/*
 byte level command interpreter of the on-chip debugger: decodes host
 commands, answers reads, loads the program counter, writes the
 register file and runs the breakpoint down counter.
 assumes bytes from the debug_serial_pin are already deserialised and
 serialised outside, all inputs synchronous to ref_clk_i, and that the
 host sends no new byte while an answer is still going out.
*/
`timescale 1ns/1ps
// Functional notes
// [RULE_01] the down counter can raise a breakpoint halt when it equals the program counter.
// [RULE_02] command 03H answers the inverted down counter, high byte then low byte.
// [RULE_03] outside debug mode command 03H answers FFFFH.
// [RULE_04] command 04H takes one more byte and loads it into the control register.
// [RULE_05] with read protection the debug mode bit can be set but never cleared, only reset clears it.
// [RULE_06] command 05H answers one byte with the control register contents.
// [RULE_07] command 06H loads the next two bytes into the program counter unless blocked by mode or protection.
// [RULE_08] command 07H answers the program counter high then low, or FFFFH when blocked.
// [RULE_09] command 08H takes an upper address byte with four zero bits, a low address byte, a size byte, then data.
// [RULE_10] a register write moves 1 to 256 bytes and size zero means 256.
// [RULE_11] outside debug mode register write bytes are taken but discarded.
// [RULE_12] with read protection only flash control registers may be written.
// [RULE_13] every command opens with its code byte and operands or answers follow in fixed order.
// [RULE_14] the register address steps by one after each stored data byte.
`include "ocd_cmd_consts.vh"

module ocd_command_interpreter (
	input wire ref_clk_i,
	input wire arst_n_i,
	input wire [7:0] rx_byte_i,
	input wire rx_valid_i,
	output wire [7:0] tx_byte_o,
	output wire tx_valid_o,
	input wire tx_ready_i,
	input wire read_protect_option_i,
	input wire [15:0] pc_i,
	output reg pc_wr_o,
	output reg [15:0] pc_wdata_o,
	output reg reg_wr_o,
	output reg [11:0] reg_addr_o,
	output reg [7:0] reg_wdata_o,
	output wire [7:0] debug_control_register_o,
	output wire debug_mode_bit_o,
	output reg breakpoint_halt_o
);

	reg [3:0] state_ff, nxt_state;
	reg [7:0] ctl_ff, nxt_ctl;
	reg [15:0] cnt_ff;
	reg [7:0] tx_data_ff, nxt_tx_data;
	reg [7:0] tx_low_ff, nxt_tx_low;
	reg two_bytes_ff, nxt_two_bytes;
	reg [7:0] pc_hi_ff, nxt_pc_hi;
	reg [11:0] addr_ff, nxt_addr;
	reg [8:0] left_ff, nxt_left;
	reg nxt_pc_wr, nxt_reg_wr;
	reg [15:0] nxt_pc_wdata;
	reg [7:0] nxt_reg_wdata;
	reg [11:0] nxt_reg_addr;

	wire dbg_mode = ctl_ff[`CTL_DEBUG_MODE_BIT];
	wire pc_open = dbg_mode & ~read_protect_option_i;
	// blocked answer word, split into bytes by part-select
	wire [15:0] blocked_word = `BLOCKED_WORD;

	// address falls inside the flash control window
	function in_flash_ctl;
		input [11:0] a;
		begin
			in_flash_ctl = (a >= `FLASH_CTL_FIRST) && (a <= `FLASH_CTL_LAST);
		end
	endfunction

	assign tx_valid_o = (state_ff == `ST_TX_FIRST) ||
		(state_ff == `ST_TX_SECOND);
	assign tx_byte_o = tx_data_ff;
	assign debug_control_register_o = ctl_ff;
	assign debug_mode_bit_o = dbg_mode;

	// command decode and operand sequencing
	always @* begin
		nxt_state = state_ff;
		nxt_ctl = ctl_ff;
		nxt_tx_data = tx_data_ff;
		nxt_tx_low = tx_low_ff;
		nxt_two_bytes = two_bytes_ff;
		nxt_pc_hi = pc_hi_ff;
		nxt_addr = addr_ff;
		nxt_left = left_ff;
		nxt_pc_wr = 1'b0;
		nxt_pc_wdata = pc_wdata_o;
		nxt_reg_wr = 1'b0;
		nxt_reg_wdata = reg_wdata_o;
		nxt_reg_addr = reg_addr_o;
		case (state_ff)
			`ST_IDLE: begin
				if (rx_valid_i) begin
					// first byte is always the command code [RULE_13]
					case (rx_byte_i)
						`CMD_RD_COUNTER: begin
							nxt_two_bytes = 1'b1;
							nxt_state = `ST_TX_FIRST;
							if (dbg_mode) begin
								nxt_tx_data = ~cnt_ff[15:8]; // [RULE_02]
								nxt_tx_low = ~cnt_ff[7:0];
							end else begin
								nxt_tx_data = blocked_word[15:8]; // [RULE_03]
								nxt_tx_low = blocked_word[7:0];
							end
						end
						`CMD_WR_CONTROL: nxt_state = `ST_CTL_DATA;
						`CMD_RD_CONTROL: begin
							nxt_two_bytes = 1'b0;
							nxt_tx_data = ctl_ff; // [RULE_06]
							nxt_state = `ST_TX_FIRST;
						end
						`CMD_WR_PC: nxt_state = `ST_PC_HI;
						`CMD_RD_PC: begin
							nxt_two_bytes = 1'b1;
							nxt_state = `ST_TX_FIRST;
							if (pc_open) begin
								nxt_tx_data = pc_i[15:8]; // [RULE_08]
								nxt_tx_low = pc_i[7:0];
							end else begin
								nxt_tx_data = blocked_word[15:8]; // [RULE_08]
								nxt_tx_low = blocked_word[7:0];
							end
						end
						`CMD_WR_REG: nxt_state = `ST_ADDR_HI;
						default: nxt_state = `ST_IDLE;
					endcase
				end
			end
			`ST_CTL_DATA: begin
				if (rx_valid_i) begin
					nxt_ctl = rx_byte_i; // [RULE_04]
					// protected device keeps debug mode once set [RULE_05]
					if (read_protect_option_i && dbg_mode)
						nxt_ctl[`CTL_DEBUG_MODE_BIT] = 1'b1;
					nxt_state = `ST_IDLE;
				end
			end
			`ST_PC_HI: begin
				if (rx_valid_i) begin
					nxt_pc_hi = rx_byte_i;
					nxt_state = `ST_PC_LO;
				end
			end
			`ST_PC_LO: begin
				if (rx_valid_i) begin
					nxt_pc_wdata = {pc_hi_ff, rx_byte_i};
					nxt_pc_wr = pc_open; // [RULE_07]
					nxt_state = `ST_IDLE;
				end
			end
			`ST_ADDR_HI: begin
				if (rx_valid_i) begin
					nxt_addr = {rx_byte_i[3:0], addr_ff[7:0]}; // [RULE_09]
					nxt_state = `ST_ADDR_LO;
				end
			end
			`ST_ADDR_LO: begin
				if (rx_valid_i) begin
					nxt_addr = {addr_ff[11:8], rx_byte_i}; // [RULE_09]
					nxt_state = `ST_SIZE;
				end
			end
			`ST_SIZE: begin
				if (rx_valid_i) begin
					// zero size stands for a full block [RULE_10]
					nxt_left = (rx_byte_i == 8'h00) ? `FULL_BLOCK :
						{1'b0, rx_byte_i};
					nxt_state = `ST_DATA;
				end
			end
			`ST_DATA: begin
				if (rx_valid_i) begin
					nxt_reg_addr = addr_ff;
					nxt_reg_wdata = rx_byte_i;
					// discard outside debug mode [RULE_11]
					// protection limits writes to flash control [RULE_12]
					nxt_reg_wr = dbg_mode &&
						(!read_protect_option_i || in_flash_ctl(addr_ff));
					nxt_addr = addr_ff + 12'h001; // [RULE_14]
					nxt_left = left_ff - 9'h001;
					if (left_ff == 9'h001)
						nxt_state = `ST_IDLE; // [RULE_10]
				end
			end
			`ST_TX_FIRST: begin
				if (tx_ready_i) begin
					if (two_bytes_ff) begin
						nxt_tx_data = tx_low_ff; // high byte went first [RULE_13]
						nxt_state = `ST_TX_SECOND;
					end else begin
						nxt_state = `ST_IDLE;
					end
				end
			end
			`ST_TX_SECOND: begin
				if (tx_ready_i)
					nxt_state = `ST_IDLE;
			end
			default: nxt_state = `ST_IDLE;
		endcase
	end

	// interpreter registers
	always @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_ff <= `ST_IDLE;
			ctl_ff <= `CTL_RESET; // only reset leaves protected debug mode
			tx_data_ff <= 8'h00;
			tx_low_ff <= 8'h00;
			two_bytes_ff <= 1'b0;
			pc_hi_ff <= 8'h00;
			addr_ff <= 12'h000;
			left_ff <= 9'h000;
			pc_wr_o <= 1'b0;
			pc_wdata_o <= 16'h0000;
			reg_wr_o <= 1'b0;
			reg_wdata_o <= 8'h00;
			reg_addr_o <= 12'h000;
		end else begin
			state_ff <= nxt_state;
			ctl_ff <= nxt_ctl;
			tx_data_ff <= nxt_tx_data;
			tx_low_ff <= nxt_tx_low;
			two_bytes_ff <= nxt_two_bytes;
			pc_hi_ff <= nxt_pc_hi;
			addr_ff <= nxt_addr;
			left_ff <= nxt_left;
			pc_wr_o <= nxt_pc_wr;
			pc_wdata_o <= nxt_pc_wdata;
			reg_wr_o <= nxt_reg_wr;
			reg_wdata_o <= nxt_reg_wdata;
			reg_addr_o <= nxt_reg_addr;
		end
	end

	// down counter and breakpoint on match with the program counter
	always @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_ff <= `COUNTER_RESET;
			breakpoint_halt_o <= 1'b0;
		end else begin
			if (ctl_ff[`CTL_COUNT_ENABLE_BIT])
				cnt_ff <= cnt_ff - 16'h0001;
			breakpoint_halt_o <= ctl_ff[`CTL_BRK_ENABLE_BIT] &&
				(cnt_ff == pc_i); // [RULE_01]
		end
	end

endmodule // ocd_command_interpreter

// >>> verif/ocd_cmd_checker_assertions.sv
/* assertions on the debug command interpreter ports.
 assumes it is bound to ocd_command_interpreter. */
`timescale 1ns/1ps
module ocd_cmd_checker (
	input wire ref_clk_i,
	input wire arst_n_i,
	input wire [7:0] tx_byte_o,
	input wire tx_valid_o,
	input wire tx_ready_i,
	input wire read_protect_option_i,
	input wire pc_wr_o,
	input wire reg_wr_o,
	input wire [11:0] reg_addr_o,
	input wire [7:0] debug_control_register_o,
	input wire debug_mode_bit_o,
	input wire breakpoint_halt_o
);
	// one clock domain, reset disables every check
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	pc_gate_a: assert property (pc_wr_o |-> debug_mode_bit_o &&
		!read_protect_option_i) else $error("pc write blocked");
	pc_pulse_a: assert property (pc_wr_o |=> !pc_wr_o)
		else $error("pc pulse long");
	reg_mode_a: assert property (reg_wr_o |-> debug_mode_bit_o)
		else $error("reg write blocked");
	reg_prot_a: assert property (reg_wr_o && read_protect_option_i
		|-> reg_addr_o >= 12'hFF8) else $error("reg write protected");
	addr_step_a: assert property (reg_wr_o && $past(reg_wr_o)
		|-> reg_addr_o == $past(reg_addr_o) + 12'h001)
		else $error("addr step");
	mode_keep_a: assert property (read_protect_option_i &&
		debug_mode_bit_o |=> debug_mode_bit_o) else $error("mode cleared");
	halt_en_a: assert property (breakpoint_halt_o |->
		$past(debug_control_register_o[6])) else $error("halt disabled");
	tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=>
		tx_valid_o && $stable(tx_byte_o)) else $error("answer dropped");
	// main scenarios reached
	cover property (reg_wr_o ##1 reg_wr_o);
	cover property (pc_wr_o);
	cover property (breakpoint_halt_o);
endmodule // ocd_cmd_checker
bind ocd_command_interpreter ocd_cmd_checker chk (.*);

// >>> verif/ocd_host_model.sv
/* debug host model: sends command bytes, takes answer bytes.
 assumes bytes move one per clock with a ready handshake. */
`timescale 1ns/1ps
module ocd_host_model (
	input wire ref_clk_i,
	output logic [7:0] host_byte_o,
	output logic host_valid_o,
	output logic host_ready_o,
	input wire [7:0] ans_byte_i,
	input wire ans_valid_i
);
	// idle lines at time zero
	initial begin
		host_byte_o = 8'h5A;
		host_valid_o = 1'b0;
		host_ready_o = 1'b0;
	end
	// offer one byte; valid stays up for the next one
	task send(input logic [7:0] b);
		@(negedge ref_clk_i);
		host_byte_o = b;
		host_valid_o = 1'b1;
	endtask
	// drop valid and scramble the released byte lines
	task idle();
		@(negedge ref_clk_i);
		host_valid_o = 1'b0;
		host_byte_o = ~host_byte_o;
	endtask
	// take one answer byte after a stall
	task recv(input int stall, output logic [7:0] b);
		do @(negedge ref_clk_i); while (ans_valid_i !== 1'b1);
		repeat (stall) @(negedge ref_clk_i);
		host_ready_o = 1'b1;
		// byte stands until the edge that takes it, so read it here
		b = ans_byte_i;
		@(posedge ref_clk_i);
		@(negedge ref_clk_i);
		host_ready_o = 1'b0;
	endtask
endmodule // ocd_host_model

// >>> verif/test_ocd_command_interpreter.sv
/* bench for the debug command interpreter.
 assumes the host model and checker are compiled first. */
`timescale 1ns/1ps
module test_ocd_command_interpreter;
	logic ref_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic read_protect_option_i = 1'b0;
	logic [15:0] pc_i = 16'h0000;
	logic [7:0] rx_byte_i;
	logic rx_valid_i, tx_ready_i;
	wire [7:0] tx_byte_o, reg_wdata_o, debug_control_register_o;
	wire tx_valid_o, pc_wr_o, reg_wr_o, debug_mode_bit_o, breakpoint_halt_o;
	wire [15:0] pc_wdata_o;
	wire [11:0] reg_addr_o;
	int errors = 0, n_checks = 0, cyc = 0, n_reg = 0, n_pc = 0, n0;
	logic [11:0] last_addr;
	logic [7:0] last_data;
	logic [15:0] w, v;
	ocd_command_interpreter dut (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.rx_byte_i(rx_byte_i),
		.rx_valid_i(rx_valid_i),
		.tx_byte_o(tx_byte_o),
		.tx_valid_o(tx_valid_o),
		.tx_ready_i(tx_ready_i),
		.read_protect_option_i(read_protect_option_i),
		.pc_i(pc_i),
		.pc_wr_o(pc_wr_o),
		.pc_wdata_o(pc_wdata_o),
		.reg_wr_o(reg_wr_o),
		.reg_addr_o(reg_addr_o),
		.reg_wdata_o(reg_wdata_o),
		.debug_control_register_o(debug_control_register_o),
		.debug_mode_bit_o(debug_mode_bit_o),
		.breakpoint_halt_o(breakpoint_halt_o)
	);
	ocd_host_model host (
		.ref_clk_i(ref_clk_i),
		.host_byte_o(rx_byte_i),
		.host_valid_o(rx_valid_i),
		.host_ready_o(tx_ready_i),
		.ans_byte_i(tx_byte_o),
		.ans_valid_i(tx_valid_o)
	);
	// 200 MHz clock
	initial forever #2.5 ref_clk_i = ~ref_clk_i;
	// count write pulses on settled outputs, cut a hang short
	always @(negedge ref_clk_i) begin
		cyc++;
		if (reg_wr_o === 1'b1) begin
			n_reg++;
			last_addr = reg_addr_o;
			last_data = reg_wdata_o;
		end
		if (pc_wr_o === 1'b1)
			n_pc++;
		if (cyc == 3000) begin
			errors++;
			test_done();
		end
	end
	task chk(input logic [15:0] g, e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %0t got %h exp %h", $time, g, e);
		end
	endtask
	task rd(input logic [7:0] c, input int n, output logic [15:0] r);
		r = 16'h0000;
		host.send(c);
		host.idle();
		for (int i = n; i > 0; i--) host.recv(2 * i - 2, r[8*i-8 +: 8]);
	endtask
	task cmd(input int n, input logic [7:0] b0, b1, b2);
		host.send(b0);
		host.send(b1);
		if (n > 2)
			host.send(b2);
		host.idle();
		repeat (2) @(negedge ref_clk_i);
	endtask
	task wr_reg(input logic [11:0] a, input logic [7:0] sz, input int n);
		host.send(8'h08);
		host.send({4'h0, a[11:8]});
		host.send(a[7:0]);
		host.send(sz);
		for (int i = 0; i < n; i++) host.send(8'(i + 8'h11));
		host.idle();
		repeat (2) @(negedge ref_clk_i);
	endtask
	task t_locked();
		rd(8'h03, 2, w);
		chk(w, 16'hFFFF);
		rd(8'h07, 2, w);
		chk(w, 16'hFFFF);
		cmd(3, 8'h06, 8'h12, 8'h34);
		wr_reg(12'h010, 8'h01, 1);
		chk(16'(n_pc + n_reg), 16'h0000);
		$display("locked test done");
	endtask
	task t_ctl();
		pc_i = 16'hFFFF;
		cmd(2, 8'h04, 8'hC0, 8'h00);
		rd(8'h05, 1, w);
		chk(w, 16'h00C0);
		chk(debug_control_register_o, 16'h00C0);
		chk(breakpoint_halt_o, 1'b1);
		rd(8'h03, 2, w);
		chk(w, 16'h0000);
		pc_i = 16'hFFFE;
		repeat (3) @(negedge ref_clk_i);
		chk(breakpoint_halt_o, 1'b0);
		$display("control test done");
	endtask
	task t_pc_count();
		cmd(3, 8'h06, 8'hBE, 8'hEF);
		chk(pc_wdata_o, 16'hBEEF);
		chk(16'(n_pc), 16'h0001);
		pc_i = 16'h2345;
		rd(8'h07, 2, w);
		chk(w, 16'h2345);
		cmd(2, 8'h04, 8'hA0, 8'h00);
		rd(8'h03, 2, w);
		rd(8'h03, 2, v);
		chk(v > w && v - w < 16'h0040, 1'b1);
		$display("pc and counter test done");
	endtask
	task t_regwr();
		n0 = n_reg;
		wr_reg(12'h0F0, 8'h00, 256);
		chk(16'(n_reg - n0), 16'h0100);
		chk(last_addr, 12'h1EF);
		chk(last_data, 8'h10);
		wr_reg(12'h305, 8'h01, 1);
		chk(last_addr, 12'h305);
		$display("register write test done");
	endtask
	task t_protect();
		read_protect_option_i = 1'b1;
		n0 = n_reg + n_pc;
		cmd(2, 8'h04, 8'h00, 8'h00);
		rd(8'h05, 1, w);
		chk(w[7], 1'b1);
		chk(debug_mode_bit_o, 1'b1);
		cmd(3, 8'h06, 8'h11, 8'h22);
		rd(8'h07, 2, w);
		chk(w, 16'hFFFF);
		wr_reg(12'hFF6, 8'h04, 4);
		chk(16'(n_reg + n_pc - n0), 16'h0002);
		chk(last_addr, 12'hFF9);
		// only a reset leaves protected debug mode
		arst_n_i = 1'b0;
		repeat (2) @(negedge ref_clk_i);
		arst_n_i = 1'b1;
		rd(8'h05, 1, w);
		chk(w, 16'h0000);
		chk(debug_mode_bit_o, 1'b0);
		$display("protect test done");
	endtask
	task test_done();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// reset for ten cycles, then the scenarios in turn
	initial begin
		repeat (10) @(negedge ref_clk_i);
		arst_n_i = 1'b1;
		t_locked();
		t_ctl();
		t_pc_count();
		t_regwr();
		t_protect();
		test_done();
	end
endmodule // test_ocd_command_interpreter
